// file: verilog/wofl_pkg.sv
// wofl package: constants, register map and carrier types of the wake and off-state fault latch
package wofl_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam int DEGLITCH_NS = 130000;
	localparam int LPO_PERIOD_NS = 10000;
	localparam int DEGLITCH_TICKS = (DEGLITCH_NS + LPO_PERIOD_NS - 1) / LPO_PERIOD_NS;
	localparam int REG2_OV_MIN_NS = 28000;
	localparam int REG2_OV_MAX_NS = 30000;
	localparam int REG2_OV_CYC = (REG2_OV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOOST_OV_MIN_NS = 72000;
	localparam int BOOST_OV_MAX_NS = 80000;
	localparam int BOOST_OV_CYC = (BOOST_OV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OFF_SETTLE_CYC = 4;
	localparam int NVM_BYTES = 16;
	localparam int N_LATCH = 17;
	localparam int L_POR = 0;
	localparam int L_CLK = 1;
	localparam int L_RTO = 2;
	localparam int L_NVM = 3;
	localparam int L_REG2 = 10;
	localparam int L_BOOST = 11;
	localparam int GRP_LO = 4;
	localparam int GRP_HI = 13;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OFF_LATCH = 8'h04;
	localparam logic [7:0] ADDR_SAFETY = 8'h08;
	localparam logic [7:0] ADDR_DETAIL = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h18;
	localparam logic [7:0] ADDR_RETAINED = 8'h1C;
	localparam int CTRL_DIAG_BIT = 0;
	localparam int CTRL_CLRWAKE_BIT = 1;
	localparam int SAF_NVM_BIT = 0;
	localparam int IRQ_W = 3;
	localparam int IRQ_CRC = 0;
	localparam int IRQ_UP = 1;
	localparam int IRQ_OFF = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_STARTUP = 3'b001,
		ST_COPY = 3'b010,
		ST_RUN = 3'b011,
		ST_GOING_OFF = 3'b100
	} wofl_state_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} wofl_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wofl_axil_rsp_t;

	typedef struct packed {
		logic clkMonErr;
		logic resetTimeout;
		logic [5:0] mainRegFault;
		logic reg2Ov;
		logic reg2Disabled;
		logic boostOv;
		logic boostDisabled;
		logic vregUv;
		logic vregOv;
		logic inputOv;
		logic errCntPowerDown;
		logic startupTimeout;
	} wofl_fault_t;
endpackage

// file: verilog/wofl_top.sv
// wofl_top: wake detector, retained off-state latches, NVM checksum checker, AXI4-Lite registers
`timescale 1ns/1ps
module wofl_top #(
	parameter int NVM_BYTES = wofl_pkg::NVM_BYTES,
	parameter int DEGLITCH_TICKS = wofl_pkg::DEGLITCH_TICKS,
	parameter int REG2_OV_CYC = wofl_pkg::REG2_OV_CYC,
	parameter int BOOST_OV_CYC = wofl_pkg::BOOST_OV_CYC,
	parameter int OFF_SETTLE_CYC = wofl_pkg::OFF_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire wofl_pkg::wofl_axil_req_t axiReq,
	output wofl_pkg::wofl_axil_rsp_t axiRsp,
	input wire logic wakeIn,
	input wire logic lpoTick,
	input wire logic analogSupplyLost,
	input wire logic internalPowerOnResetN,
	input wire logic nvmLoaded,
	output logic [$clog2(NVM_BYTES)-1:0] nvmAddr,
	input wire logic [7:0] nvmData,
	input wire wofl_pkg::wofl_fault_t faultIn,
	output logic offState,
	output logic powerUpReq,
	output logic wakeLatch,
	output logic irq
);
	localparam int AW = $clog2(NVM_BYTES);
	localparam int DGW = $clog2(DEGLITCH_TICKS + 1);
	localparam int R2W = $clog2(REG2_OV_CYC + 1);
	localparam int BOW = $clog2(BOOST_OV_CYC + 1);
	localparam int OSW = $clog2(OFF_SETTLE_CYC + 1);
	localparam logic [AW-1:0] REF_IDX = AW'(NVM_BYTES - 1);
	localparam logic [DGW-1:0] DG_LAST = DGW'(DEGLITCH_TICKS);
	localparam logic [R2W-1:0] R2_LAST = R2W'(REG2_OV_CYC);
	localparam logic [BOW-1:0] BO_LAST = BOW'(BOOST_OV_CYC);
	localparam logic [OSW-1:0] OS_LAST = OSW'(OFF_SETTLE_CYC);
	localparam int NL = wofl_pkg::N_LATCH;

	// one byte of the MSB-first remainder update
	function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		logic fb;
		r = c;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = r[7] ^ d[i];
			r = {r[6:0], 1'b0};
			if (fb) begin
				r = r ^ wofl_pkg::CRC_POLY;
			end
		end
		return r;
	endfunction

	wofl_pkg::wofl_state_t stQ;
	wofl_pkg::wofl_state_t stD;
	logic [OSW-1:0] settleQ;
	logic [DGW-1:0] dgCntQ;
	logic wakeLatchQ;
	logic [R2W-1:0] r2CntQ;
	logic [BOW-1:0] boCntQ;
	logic [AW-1:0] crcIdxQ;
	logic [7:0] crcQ;
	logic [NL-1:0] pendQ;
	logic [NL-1:0] retainedQ;
	logic [4:0] offLatchStatQ;
	logic [NL-1:0] detailQ;
	logic nvmErrQ;
	logic diagQ;
	logic [wofl_pkg::IRQ_W-1:0] irqStatQ;
	logic [wofl_pkg::IRQ_W-1:0] irqMaskQ;
	logic bvalidQ;
	logic [1:0] brespQ;
	logic rvalidQ;
	logic [31:0] rdataQ;
	logic [1:0] rrespQ;

	// power-state decode
	wire isOff = (stQ == wofl_pkg::ST_OFF);
	wire isGoingOff = (stQ == wofl_pkg::ST_GOING_OFF);
	wire isRun = (stQ == wofl_pkg::ST_RUN);
	wire isCopy = (stQ == wofl_pkg::ST_COPY);
	wire isStartup = (stQ == wofl_pkg::ST_STARTUP);
	wire operating = isRun || isCopy || isStartup;
	wire settleDone = (settleQ == OS_LAST);

	// bus decode
	wire wrGo = clkEn && axiReq.awvalid && axiReq.wvalid && !bvalidQ;
	wire lane0 = axiReq.wstrb[0];
	wire [7:0] wAddr = axiReq.awaddr;
	wire wrCtrl = wrGo && lane0 && (wAddr == wofl_pkg::ADDR_CTRL);
	wire wrSafety = wrGo && lane0 && (wAddr == wofl_pkg::ADDR_SAFETY);
	wire wrIrqStat = wrGo && lane0 && (wAddr == wofl_pkg::ADDR_IRQ_STAT);
	wire wrIrqMask = wrGo && lane0 && (wAddr == wofl_pkg::ADDR_IRQ_MASK);
	wire wMapped = (wAddr == wofl_pkg::ADDR_CTRL) || (wAddr == wofl_pkg::ADDR_SAFETY)
		|| (wAddr == wofl_pkg::ADDR_IRQ_STAT) || (wAddr == wofl_pkg::ADDR_IRQ_MASK)
		|| (wAddr == wofl_pkg::ADDR_OFF_LATCH) || (wAddr == wofl_pkg::ADDR_DETAIL)
		|| (wAddr == wofl_pkg::ADDR_STATE) || (wAddr == wofl_pkg::ADDR_RETAINED);
	wire [7:0] wLow = axiReq.wdata[7:0];
	wire clrWakeCmd = wrCtrl && wLow[wofl_pkg::CTRL_CLRWAKE_BIT];
	// reads stall through start-up and while the retained latches are being transferred
	wire copyBusy = isStartup || isCopy;
	wire rdGo = clkEn && axiReq.arvalid && !rvalidQ && !copyBusy;

	// checksum engine, idle in every state but run
	wire crcAtRef = (crcIdxQ == REF_IDX);
	wire [7:0] crcNext = crcByte(crcQ, nvmData);
	wire crcMismatch = isRun && crcAtRef && (crcQ != nvmData);

	// persistence timers for the two overvoltage cases
	wire r2Persist = operating && faultIn.reg2Disabled && faultIn.reg2Ov;
	wire boPersist = operating && faultIn.boostDisabled && faultIn.boostOv;
	wire r2Fault = r2Persist && (r2CntQ == R2_LAST);
	wire boFault = boPersist && (boCntQ == BO_LAST);

	// all off-state causes, one bit per retained latch
	logic [NL-1:0] cause;
	assign cause[wofl_pkg::L_POR] = isRun && !internalPowerOnResetN;
	assign cause[wofl_pkg::L_CLK] = faultIn.clkMonErr;
	assign cause[wofl_pkg::L_RTO] = faultIn.resetTimeout;
	assign cause[wofl_pkg::L_NVM] = crcMismatch;
	assign cause[9:4] = faultIn.mainRegFault;
	assign cause[wofl_pkg::L_REG2] = r2Fault;
	assign cause[wofl_pkg::L_BOOST] = boFault;
	assign cause[12] = faultIn.vregUv;
	assign cause[13] = faultIn.vregOv;
	assign cause[14] = faultIn.inputOv;
	assign cause[15] = faultIn.errCntPowerDown;
	assign cause[16] = faultIn.startupTimeout;
	wire [NL-1:0] liveCause = (operating || isGoingOff) ? cause : '0;
	wire goOff = operating && (|liveCause);

	// wake deglitch on the low-power tick
	wire dgDone = (dgCntQ == DG_LAST);
	wire wakeSet = isOff && wakeIn && lpoTick && dgDone;
	// clear held active for the whole shutdown
	wire wakeClr = clrWakeCmd || goOff || isGoingOff;

	// merged regulator failure bit
	wire grpFail = |retainedQ[wofl_pkg::GRP_HI:wofl_pkg::GRP_LO];

	// interrupt events
	logic [wofl_pkg::IRQ_W-1:0] irqEv;
	assign irqEv[wofl_pkg::IRQ_CRC] = crcMismatch;
	assign irqEv[wofl_pkg::IRQ_UP] = isCopy;
	assign irqEv[wofl_pkg::IRQ_OFF] = goOff;
	wire [wofl_pkg::IRQ_W-1:0] irqW1c = wrIrqStat ? wLow[wofl_pkg::IRQ_W-1:0] : '0;

	// power-state sequencing
	always_comb begin
		stD = stQ;
		case (stQ)
			wofl_pkg::ST_OFF: begin
				if (wakeLatchQ) begin
					stD = wofl_pkg::ST_STARTUP;
				end
			end
			wofl_pkg::ST_STARTUP: begin
				if (goOff) begin
					stD = wofl_pkg::ST_GOING_OFF;
				end else if (internalPowerOnResetN && nvmLoaded) begin
					stD = wofl_pkg::ST_COPY;
				end
			end
			wofl_pkg::ST_COPY: begin
				stD = goOff ? wofl_pkg::ST_GOING_OFF : wofl_pkg::ST_RUN;
			end
			wofl_pkg::ST_RUN: begin
				if (goOff) begin
					stD = wofl_pkg::ST_GOING_OFF;
				end
			end
			wofl_pkg::ST_GOING_OFF: begin
				if (settleDone) begin
					stD = wofl_pkg::ST_OFF;
				end
			end
			default: begin
				stD = wofl_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stQ <= wofl_pkg::ST_OFF;
			settleQ <= '0;
		end else if (clkEn) begin
			stQ <= stD;
			settleQ <= isGoingOff ? settleQ + OSW'(1) : '0;
		end
	end

	// apart from the bus registers and the supply-loss wipe of the retained latches, only this counter and the wake latch move while off
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dgCntQ <= '0;
		end else if (clkEn) begin
			if (!isOff || !wakeIn) begin
				dgCntQ <= '0;
			end else if (lpoTick && !dgDone) begin
				dgCntQ <= dgCntQ + DGW'(1);
			end
		end
	end

	// a wake completing in the cycle of a clear command survives it; shutdown never meets a set
	always_ff @(posedge clk) begin
		if (sys_rst || analogSupplyLost) begin
			wakeLatchQ <= 1'b0;
		end else if (clkEn) begin
			if (wakeSet) begin
				wakeLatchQ <= 1'b1;
			end else if (wakeClr) begin
				wakeLatchQ <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r2CntQ <= '0;
			boCntQ <= '0;
		end else if (clkEn) begin
			r2CntQ <= (r2Persist && !r2Fault) ? r2CntQ + R2W'(1) : '0;
			boCntQ <= (boPersist && !boFault) ? boCntQ + BOW'(1) : '0;
		end
	end

	// one NVM byte per cycle, then compare against the stored reference
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			crcIdxQ <= '0;
			crcQ <= wofl_pkg::CRC_INIT;
		end else if (clkEn) begin
			if (!isRun || crcAtRef) begin
				crcIdxQ <= '0;
				crcQ <= wofl_pkg::CRC_INIT;
			end else begin
				crcIdxQ <= crcIdxQ + AW'(1);
				crcQ <= crcNext;
			end
		end
	end

	// causes gathered during shutdown, committed to the retained latches at off entry
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pendQ <= '0;
		end else if (clkEn) begin
			if (isGoingOff && settleDone) begin
				pendQ <= '0;
			end else begin
				pendQ <= pendQ | liveCause;
			end
		end
	end

	// retained domain: losing the analog supply wipes it
	always_ff @(posedge clk) begin
		if (sys_rst || analogSupplyLost) begin
			retainedQ <= '0;
		end else if (clkEn) begin
			if (isGoingOff && settleDone) begin
				retainedQ <= retainedQ | pendQ | liveCause;
			end else if (isCopy) begin
				retainedQ <= '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			offLatchStatQ <= '0;
			detailQ <= '0;
		end else if (clkEn && isCopy) begin
			offLatchStatQ <= {grpFail, retainedQ[3:0]};
			detailQ <= retainedQ;
		end
	end

	// safety status flag: any set wins over a same-cycle software clear
	wire nvmErrSet = crcMismatch || diagQ || (isCopy && retainedQ[wofl_pkg::L_NVM]);
	wire nvmErrClr = wrSafety && wLow[wofl_pkg::SAF_NVM_BIT];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nvmErrQ <= 1'b0;
		end else if (clkEn) begin
			if (nvmErrSet) begin
				nvmErrQ <= 1'b1;
			end else if (nvmErrClr) begin
				nvmErrQ <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			diagQ <= 1'b0;
			irqMaskQ <= wofl_pkg::IRQ_MASK_RST;
		end else if (clkEn) begin
			if (wrCtrl) begin
				diagQ <= wLow[wofl_pkg::CTRL_DIAG_BIT];
			end
			if (wrIrqMask) begin
				irqMaskQ <= wLow[wofl_pkg::IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqStatQ <= '0;
		end else if (clkEn) begin
			irqStatQ <= irqEv | (irqStatQ & ~irqW1c);
		end
	end

	// write response
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bvalidQ <= 1'b0;
			brespQ <= wofl_pkg::RESP_OKAY;
		end else if (clkEn) begin
			if (wrGo) begin
				bvalidQ <= 1'b1;
				brespQ <= wMapped ? wofl_pkg::RESP_OKAY : wofl_pkg::RESP_SLVERR;
			end else if (axiReq.bready) begin
				bvalidQ <= 1'b0;
			end
		end
	end

	// read mux
	wire [7:0] rAddr = axiReq.araddr;
	logic [31:0] rMux;
	logic rHit;
	always_comb begin
		rMux = '0;
		rHit = 1'b1;
		if (rAddr == wofl_pkg::ADDR_CTRL) begin
			rMux[wofl_pkg::CTRL_DIAG_BIT] = diagQ;
		end else if (rAddr == wofl_pkg::ADDR_OFF_LATCH) begin
			rMux[4:0] = offLatchStatQ;
		end else if (rAddr == wofl_pkg::ADDR_SAFETY) begin
			rMux[wofl_pkg::SAF_NVM_BIT] = nvmErrQ;
		end else if (rAddr == wofl_pkg::ADDR_DETAIL) begin
			rMux[NL-1:0] = detailQ;
		end else if (rAddr == wofl_pkg::ADDR_IRQ_STAT) begin
			rMux[wofl_pkg::IRQ_W-1:0] = irqStatQ;
		end else if (rAddr == wofl_pkg::ADDR_IRQ_MASK) begin
			rMux[wofl_pkg::IRQ_W-1:0] = irqMaskQ;
		end else if (rAddr == wofl_pkg::ADDR_STATE) begin
			rMux[2:0] = stQ;
			rMux[3] = wakeLatchQ;
		end else if (rAddr == wofl_pkg::ADDR_RETAINED) begin
			rMux[NL-1:0] = retainedQ;
		end else begin
			rHit = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rvalidQ <= 1'b0;
			rdataQ <= '0;
			rrespQ <= wofl_pkg::RESP_OKAY;
		end else if (clkEn) begin
			if (rdGo) begin
				rvalidQ <= 1'b1;
				rdataQ <= rMux;
				rrespQ <= rHit ? wofl_pkg::RESP_OKAY : wofl_pkg::RESP_SLVERR;
			end else if (axiReq.rready) begin
				rvalidQ <= 1'b0;
			end
		end
	end

	assign axiRsp = '{
		awready: wrGo,
		wready: wrGo,
		bvalid: bvalidQ,
		bresp: brespQ,
		arready: rdGo,
		rvalid: rvalidQ,
		rdata: rdataQ,
		rresp: rrespQ
	};
	assign nvmAddr = crcIdxQ;
	assign offState = isOff;
	assign powerUpReq = isStartup;
	assign wakeLatch = wakeLatchQ;
	assign irq = |(irqStatQ & irqMaskQ);
endmodule

// file: verif/wofl_top_chk.sv
// checker: wake, off-state and register bus timing of wofl_top
`timescale 1ns/1ps
module wofl_top_chk #(
	parameter int NVM_BYTES = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire wofl_pkg::wofl_axil_req_t axiReq,
	input wire wofl_pkg::wofl_axil_rsp_t axiRsp,
	input wire logic wakeIn,
	input wire logic lpoTick,
	input wire logic analogSupplyLost,
	input wire logic internalPowerOnResetN,
	input wire logic nvmLoaded,
	input wire logic [$clog2(NVM_BYTES)-1:0] nvmAddr,
	input wire logic [7:0] nvmData,
	input wire wofl_pkg::wofl_fault_t faultIn,
	input wire logic offState,
	input wire logic powerUpReq,
	input wire logic wakeLatch,
	input wire logic irq
);
	// timed overvoltage inputs are left out: they only count as faults after a delay
	wire logic anyFault = |{faultIn.clkMonErr, faultIn.resetTimeout, faultIn.mainRegFault,
		faultIn.vregUv, faultIn.vregOv, faultIn.inputOv, faultIn.errCntPowerDown,
		faultIn.startupTimeout};
	wire logic wrReq = axiReq.awvalid && axiReq.wvalid;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || !clkEn);

	AST_OFF_QUIET: assert property (offState && !wakeLatch |=> offState)
		else $error("left off state without a wake latch");
	AST_WAKE_SET: assert property ($rose(wakeLatch) |-> $past(lpoTick) && $past(wakeIn, 8))
		else $error("wake latch set without a deglitched wake");
	AST_WAKE_HOLD: assert property ((offState || powerUpReq) && wakeLatch && !analogSupplyLost
		&& !anyFault && !wrReq |=> wakeLatch)
		else $error("wake latch dropped without a clearing event");
	AST_GOING_OFF_CLR: assert property (!offState && anyFault |=> ##1 !wakeLatch [*3])
		else $error("wake latch not held clear on the way off");
	AST_OFF_REACH: assert property (!offState && anyFault |-> ##[1:8] offState)
		else $error("fault did not reach the off state");
	AST_PU_FROM_OFF: assert property ($rose(powerUpReq) |-> $past(offState) && $past(wakeLatch))
		else $error("power-up without a latched wake");
	AST_STARTUP_WAIT: assert property (powerUpReq && !(internalPowerOnResetN && nvmLoaded)
		&& !anyFault |=> powerUpReq)
		else $error("start-up left before reset release and load");
	AST_READ_HOLD: assert property (powerUpReq |-> !axiRsp.arready)
		else $error("read accepted before latch copy");
	AST_WR_ANSWER: assert property (wrReq && axiRsp.awready |=> axiRsp.bvalid)
		else $error("write response missing");
	AST_RD_STAND: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid
		&& $stable(axiRsp.rdata))
		else $error("read data not held");

	cover property ($rose(powerUpReq));
	cover property (!offState && anyFault);
	cover property (axiRsp.bvalid && axiRsp.bresp == 2'h2);
endmodule

bind wofl_top wofl_top_chk #(.NVM_BYTES(NVM_BYTES)) u_wofl_top_chk (.clk(clk), .sys_rst(sys_rst),
	.clkEn(clkEn), .axiReq(axiReq), .axiRsp(axiRsp), .wakeIn(wakeIn), .lpoTick(lpoTick),
	.analogSupplyLost(analogSupplyLost), .internalPowerOnResetN(internalPowerOnResetN),
	.nvmLoaded(nvmLoaded), .nvmAddr(nvmAddr), .nvmData(nvmData), .faultIn(faultIn),
	.offState(offState), .powerUpReq(powerUpReq), .wakeLatch(wakeLatch), .irq(irq));

// file: verif/wofl_nvm_model.sv
// nonvolatile memory model: combinational byte read, reference checksum in the top byte
`timescale 1ns/1ps
module wofl_nvm_model #(
	parameter int NB = 4
) (
	input wire logic [$clog2(NB)-1:0] nvmAddr,
	input wire logic [8*NB-1:0] img,
	output logic [7:0] nvmData
);
	assign nvmData = img[8*nvmAddr +: 8];
endmodule

// file: verif/tb_top.sv
// testbench: wake, retained latches, checksum and registers of wofl_top
`timescale 1ns/1ps
module tb_top;
	localparam int NB = 4;
	logic clk, sysRst, wakeIn, lpoTick, supLost, porN, nvmLd, crpt;
	logic offSt, puReq, wLat, irq;
	wofl_pkg::wofl_axil_req_t rq;
	wofl_pkg::wofl_axil_rsp_t rsp;
	wofl_pkg::wofl_fault_t flt;
	logic [1:0] nAddr;
	logic [7:0] nData;
	logic [8*NB-9:0] body;
	logic [8*NB-1:0] img;
	logic [31:0] d;
	logic [1:0] r;
	int failures, num_checks, lpoCnt;

	wofl_top #(.NVM_BYTES(NB), .DEGLITCH_TICKS(2), .REG2_OV_CYC(8), .BOOST_OV_CYC(16),
		.OFF_SETTLE_CYC(4)) u_wofl_top (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1), .axiReq(rq),
		.axiRsp(rsp), .wakeIn(wakeIn), .lpoTick(lpoTick), .analogSupplyLost(supLost),
		.internalPowerOnResetN(porN), .nvmLoaded(nvmLd), .nvmAddr(nAddr), .nvmData(nData),
		.faultIn(flt), .offState(offSt), .powerUpReq(puReq), .wakeLatch(wLat), .irq(irq));
	wofl_nvm_model #(.NB(NB)) u_wofl_nvm_model (.nvmAddr(nAddr), .img(img), .nvmData(nData));

	function automatic logic [7:0] crc8(input logic [8*NB-9:0] m);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 0; i < NB-1; i++)
			for (int b = 7; b >= 0; b--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ m[8*i+b]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// a corrupted image flips every bit of the stored reference
	assign img = {crc8(body) ^ {8{crpt}}, body};

	function automatic wofl_pkg::wofl_fault_t fv(input int i);
		case (i)
			1: return 17'h10000;
			2: return 17'h08000;
			4, 5, 6, 7, 8, 9: return 17'h00200 << (i-4);
			10: return 17'h00180;
			11: return 17'h00060;
			12: return 17'h00010;
			13: return 17'h00008;
			14: return 17'h00004;
			15: return 17'h00002;
			16: return 17'h00001;
			default: return 17'h00000;
		endcase
	endfunction
	function automatic logic [31:0] ol(input int i);
		return (i < 4) ? 32'h1 << i : ((i < 14) ? 32'h10 : 32'h0);
	endfunction

	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wdata <= v;
		rq.wstrb <= 4'hF;
		rq.bready <= 1'b1;
		do @(posedge clk); while (rsp.awready !== 1'b1);
		rq.awvalid <= 1'b0;
		rq.wvalid <= 1'b0;
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		rq.bready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		// a late rready lets the read data have to stand
		repeat ($urandom_range(0, 2)) @(posedge clk);
		rq.rready <= 1'b1;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		rq.rready <= 1'b0;
		chk(d, e);
	endtask

	task pu(input int dl);
		logic [31:0] rv;
		rv = $urandom;
		body <= rv[8*NB-9:0];
		porN <= 1'b0;
		nvmLd <= 1'b0;
		wakeIn <= 1'b1;
		for (int n = 0; n < 200 && puReq !== 1'b1; n++) @(posedge clk);
		wakeIn <= 1'b0;
		fork
			rc(wofl_pkg::ADDR_STATE, 32'h0B);
			begin
				repeat (dl) @(posedge clk);
				porN <= 1'b1;
				nvmLd <= 1'b1;
			end
		join
		chk(32'(irq), 32'h1);
		wr(wofl_pkg::ADDR_IRQ_STAT, 32'h7);
		chk(32'(irq), 32'h0);
		repeat (4*NB) @(posedge clk);
		chk(32'(offSt), 32'h0);
	endtask

	task inj(input int i);
		if (i == 0)
			porN <= 1'b0;
		if (i == 3)
			crpt <= 1'b1;
		if (i == 10 || i == 11) begin
			// just short of the persistence limit: must stay running
			flt <= fv(i);
			repeat ((i == 10) ? 8 : 16) @(posedge clk);
			flt <= '0;
			repeat (4) @(posedge clk);
			chk(32'(offSt), 32'h0);
		end
		flt <= fv(i);
		for (int n = 0; n < 100 && offSt !== 1'b1; n++) @(posedge clk);
		chk(32'(offSt), 32'h1);
		rc(wofl_pkg::ADDR_IRQ_STAT, (i == 3) ? 32'h5 : 32'h4);
		flt <= '0;
		crpt <= 1'b0;
		rc(wofl_pkg::ADDR_RETAINED, 32'h1 << i);
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		lpoCnt <= (lpoCnt == 4) ? 0 : lpoCnt + 1;
		lpoTick <= (lpoCnt == 4);
	end

	task end_of_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		end_of_test;
	end

	initial begin
		{sysRst, wakeIn, supLost, porN, nvmLd, crpt} = 6'h20;
		rq = '0;
		flt = '0;
		body = '0;
		failures = 0;
		num_checks = 0;
		void'($urandom(80189));
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		rc(wofl_pkg::ADDR_STATE, 32'h0);
		rc(wofl_pkg::ADDR_IRQ_MASK, 32'h0);
		rc(8'h20, 32'h0);
		chk(32'(r), 32'(wofl_pkg::RESP_SLVERR));
		wr(8'h24, 32'h0);
		chk(32'(r), 32'(wofl_pkg::RESP_SLVERR));
		wr(wofl_pkg::ADDR_IRQ_MASK, 32'h2);
		// two ticks of wake are too short to latch
		wakeIn <= 1'b1;
		repeat (9) @(posedge clk);
		wakeIn <= 1'b0;
		repeat (12) @(posedge clk);
		chk(32'(wLat), 32'h0);
		pu($urandom_range(0, 20));
		rc(wofl_pkg::ADDR_DETAIL, 32'h0);
		for (int i = 0; i < 17; i++) begin
			inj(i);
			pu($urandom_range(0, 20));
			rc(wofl_pkg::ADDR_DETAIL, 32'h1 << i);
			rc(wofl_pkg::ADDR_OFF_LATCH, ol(i));
			rc(wofl_pkg::ADDR_SAFETY, (i == 3) ? 32'h1 : 32'h0);
			rc(wofl_pkg::ADDR_RETAINED, 32'h0);
			wr(wofl_pkg::ADDR_SAFETY, 32'h1);
		end
		wr(wofl_pkg::ADDR_CTRL, 32'h1);
		rc(wofl_pkg::ADDR_SAFETY, 32'h1);
		wr(wofl_pkg::ADDR_CTRL, 32'h0);
		wr(wofl_pkg::ADDR_SAFETY, 32'h1);
		rc(wofl_pkg::ADDR_SAFETY, 32'h0);
		wr(wofl_pkg::ADDR_CTRL, 32'h2);
		chk(32'(wLat), 32'h0);
		rc(wofl_pkg::ADDR_STATE, 32'h3);
		inj(14);
		supLost <= 1'b1;
		@(posedge clk);
		supLost <= 1'b0;
		rc(wofl_pkg::ADDR_RETAINED, 32'h0);
		pu($urandom_range(0, 20));
		rc(wofl_pkg::ADDR_DETAIL, 32'h0);
		end_of_test;
	end
endmodule
